// ### rtl/pdhf_elastic_store.sv
`timescale 1ns/1ps
module pdhf_elastic_store
    import pdhf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [STORE_AW-1:0] wr_addr,
    input wire logic wr_data,
    input wire logic [STORE_AW-1:0] rd_addr,
    output logic rd_data
);
    logic mem [STORE_DEPTH];

    // Write port
    always_ff @(posedge clk_sys)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read, valid one cycle after the address settles
    always_ff @(posedge clk_sys)
    begin
        rd_data <= mem[rd_addr];
    end
endmodule

// ### rtl/pdhf_frame_pos.sv
`timescale 1ns/1ps
module pdhf_frame_pos
    import pdhf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic tick,
    input wire logic frame_start,
    output logic [11:0] pos,
    output logic locked
);
    // Bit position, forced to zero by the frame start marker
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pos <= 12'h000;
        end
        else if (tick)
        begin
            if (frame_start || pos == 12'(FRAME_BITS - 1))
            begin
                pos <= 12'h000;
            end
            else
            begin
                pos <= pos + 12'h001;
            end
        end
    end

    // Position means nothing until the first marker arrives
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            locked <= 1'b0;
        end
        else if (tick && frame_start)
        begin
            locked <= 1'b1;
        end
    end
endmodule

// ### rtl/pdhf_path_framer.sv
`timescale 1ns/1ps
module pdhf_path_framer
    import pdhf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic path_timing_clock,
    input wire logic path_timing_frame_start,
    input wire logic payload_data_in,
    input wire logic [2:0] national_use_bits,
    output logic line_tx_data,
    output logic line_tx_frame_start,
    output logic payload_data_out,
    output logic payload_drive_en,
    output logic other_source_deny,
    input wire logic tributary_data_in,
    input wire logic tributary_clock_in,
    input wire logic mapper_activate,
    input wire logic [2:0] tributary_slot,
    output logic [6:0] store_fill,
    output logic justify_flag,
    input wire logic line_rx_data,
    input wire logic line_rx_clock,
    input wire logic line_rx_frame_start,
    input wire logic server_signal_fail_in,
    input wire logic termination_point_setting,
    input wire logic remote_defect_report_en,
    input wire logic server_fail_report_en,
    input wire logic one_second_tick,
    input wire logic equipment_defect,
    input wire logic [3:0] extract_activate,
    output logic trail_signal_fail_out,
    output logic remote_defect_request,
    output logic remote_defect_condition,
    output logic remote_defect_correlated,
    output logic server_fail_correlated,
    output logic near_block_error,
    output logic [COUNT_W-1:0] near_errored_block_count,
    output logic near_defect_second,
    output logic far_defect_second,
    output logic pm_valid,
    output logic rx_payload_data,
    output logic payload_frame_start,
    output logic [3:0] extract_fail
);
    // Pin order: path clk, path fs, trib clk, trib data, rx clk, rx data, rx fs
    logic [6:0] sync1;
    logic [6:0] sync2;
    logic path_clk_prev;
    logic trib_clk_prev;
    logic rx_clk_prev;
    logic path_tick;
    logic trib_tick;
    logic rx_tick;
    logic path_emit;
    logic rx_emit;
    logic rx_bit;
    logic [11:0] tx_pos;
    logic tx_locked;
    logic [11:0] rx_pos;
    logic rx_locked;
    logic [6:0] wr_ptr;
    logic [6:0] rd_ptr;
    logic store_rd_data;
    logic store_wr_en;
    logic slot_valid;
    logic [1:0] slot_idx;
    logic mine;
    logic mapper_bit;
    logic read_bit;
    logic point_bit;
    logic monitored_point;
    logic trail_fail_action;
    logic remote_defect_action;
    logic fas_err;
    logic bit_bad;
    logic block_bad;
    logic block_done;
    logic [2:0] rdi_cnt;
    logic [COUNT_W-1:0] ebc_acc;
    logic nds_seen;
    logic fds_seen;

    // Two-stage synchronisers for every pin from the link side
    always_ff @(posedge clk_sys)
    begin
        sync1 <= {line_rx_frame_start, line_rx_data, line_rx_clock, tributary_data_in,
                  tributary_clock_in, path_timing_frame_start, path_timing_clock};
        sync2 <= sync1;
    end

    // Rising edges of the sampled clocks; link clocks must stay well below clk_sys/2
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            path_clk_prev <= 1'b0;
            trib_clk_prev <= 1'b0;
            rx_clk_prev <= 1'b0;
            path_emit <= 1'b0;
            rx_emit <= 1'b0;
        end
        else
        begin
            path_clk_prev <= sync2[0];
            trib_clk_prev <= sync2[2];
            rx_clk_prev <= sync2[4];
            path_emit <= path_tick;
            rx_emit <= rx_tick;
        end
    end

    assign path_tick = sync2[0] && !path_clk_prev;
    assign trib_tick = sync2[2] && !trib_clk_prev;
    assign rx_tick = sync2[4] && !rx_clk_prev;

    // Transmit and receive frame positions
    pdhf_frame_pos u_tx_pos (
        .clk_sys(clk_sys),
        .reset(reset),
        .tick(path_tick),
        .frame_start(sync2[1]),
        .pos(tx_pos),
        .locked(tx_locked)
    );

    pdhf_frame_pos u_rx_pos (
        .clk_sys(clk_sys),
        .reset(reset),
        .tick(rx_tick),
        .frame_start(sync2[6]),
        .pos(rx_pos),
        .locked(rx_locked)
    );

    // Elastic store, 64 bits covers ppm drift between justification chances
    pdhf_elastic_store u_store (
        .clk_sys(clk_sys),
        .wr_en(store_wr_en),
        .wr_addr(wr_ptr[STORE_AW-1:0]),
        .wr_data(sync2[3]),
        .rd_addr(rd_ptr[STORE_AW-1:0]),
        .rd_data(store_rd_data)
    );

    assign store_fill = wr_ptr - rd_ptr;
    assign store_wr_en = trib_tick && (store_fill < STORE_FULL);

    // Write pointer runs on tributary clock edges; a full store drops bits
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            wr_ptr <= 7'h00;
        end
        else if (store_wr_en)
        begin
            wr_ptr <= wr_ptr + 7'h01;
        end
    end

    // Slot decode; values outside 1..4 select nothing
    assign slot_valid = (tributary_slot >= 3'h1) && (tributary_slot <= 3'h4);
    assign slot_idx = 2'(tributary_slot - 3'h1);
    assign mine = mapper_activate && slot_valid && tx_locked && (tx_pos >= 12'(OVH_BITS))
        && (tx_pos[1:0] == slot_idx);

    // Content of our slot at this position
    always_comb
    begin
        mapper_bit = store_rd_data;
        read_bit = 1'b0;
        if (is_ctrl(tx_pos))
        begin
            mapper_bit = justify_flag;
        end
        else if (is_just(tx_pos) && justify_flag)
        begin
            mapper_bit = 1'b0;
        end
        else
        begin
            read_bit = store_fill != 7'h00;
        end
    end

    // Read side steps on our data bits when active, gated by the justification choice; inactive, it drains fill down to STORE_MID
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rd_ptr <= 7'h00;
        end
        else if (!mapper_activate)
        begin
            if (store_fill > STORE_MID)
            begin
                rd_ptr <= rd_ptr + 7'h01;
            end
        end
        else if (path_emit && mine && read_bit)
        begin
            rd_ptr <= rd_ptr + 7'h01;
        end
    end

    // Justification decided once per frame at the first bit
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            justify_flag <= 1'b0;
        end
        else if (path_emit && tx_pos == 12'h000)
        begin
            justify_flag <= store_fill < STORE_MID;
        end
    end

    // Shared payload point: the active mapper owns its slot, others are shut out
    assign point_bit = mine ? mapper_bit : payload_data_in;
    assign other_source_deny = mapper_activate;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            payload_data_out <= 1'b0;
            payload_drive_en <= 1'b0;
        end
        else if (path_emit || !mapper_activate) // Deactivation releases the point at once
        begin
            payload_data_out <= point_bit;
            payload_drive_en <= mine;
        end
    end

    // Trail source: overhead then payload untouched
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            line_tx_data <= 1'b0;
            line_tx_frame_start <= 1'b0;
        end
        else if (path_emit)
        begin
            line_tx_frame_start <= tx_pos == 12'h000;
            if (tx_pos < 12'(FAS_BITS))
            begin
                line_tx_data <= FAS_PATTERN[4'(11 - int'(tx_pos))];
            end
            else if (tx_pos == RDI_POS)
            begin
                line_tx_data <= remote_defect_request;
            end
            else if (tx_pos < 12'(OVH_BITS))
            begin
                line_tx_data <= national_use_bits[2'(2 - int'(tx_pos - NAT_FIRST_POS))];
            end
            else
            begin
                line_tx_data <= point_bit;
            end
        end
    end

    // Sink: capture the received bit on its clock edge
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rx_bit <= 1'b0;
        end
        else if (rx_tick)
        begin
            rx_bit <= sync2[5];
        end
    end

    // Alignment check across the first twelve bits
    assign bit_bad = rx_bit != FAS_PATTERN[4'(11 - int'(rx_pos[3:0]))];
    assign block_bad = ((rx_pos == 12'h000) ? 1'b0 : fas_err) | bit_bad;
    assign block_done = rx_emit && rx_locked && rx_pos == 12'(FAS_BITS - 1);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            fas_err <= 1'b0;
            near_block_error <= 1'b0;
        end
        else
        begin
            near_block_error <= block_done && block_bad;
            if (rx_emit && rx_pos < 12'(FAS_BITS))
            begin
                fas_err <= block_bad;
            end
        end
    end

    // Remote defect bit must hold a new value for five frames before it counts
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rdi_cnt <= 3'h0;
            remote_defect_condition <= 1'b0;
        end
        else if (rx_emit && rx_locked && rx_pos == RDI_POS)
        begin
            if (rx_bit == remote_defect_condition)
            begin
                rdi_cnt <= 3'h0;
            end
            else if (rdi_cnt == RDI_PERSIST - 3'h1)
            begin
                rdi_cnt <= 3'h0;
                remote_defect_condition <= rx_bit;
            end
            else
            begin
                rdi_cnt <= rdi_cnt + 3'h1;
            end
        end
    end

    // Received stream handed on toward the extraction users
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rx_payload_data <= 1'b0;
            payload_frame_start <= 1'b0;
        end
        else if (rx_emit)
        begin
            rx_payload_data <= rx_bit;
            payload_frame_start <= rx_locked && rx_pos == 12'h000;
        end
    end

    // Consequent actions and correlations
    assign trail_fail_action = server_signal_fail_in;
    assign remote_defect_action = server_signal_fail_in;
    assign monitored_point = termination_point_setting == TP_MONITORED;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            trail_signal_fail_out <= 1'b0;
            remote_defect_request <= 1'b0;
            remote_defect_correlated <= 1'b0;
            server_fail_correlated <= 1'b0;
            extract_fail <= 4'h0;
        end
        else
        begin
            trail_signal_fail_out <= trail_fail_action;
            remote_defect_request <= remote_defect_action;
            remote_defect_correlated <= remote_defect_condition && monitored_point
                && remote_defect_report_en;
            server_fail_correlated <= server_signal_fail_in && monitored_point
                && server_fail_report_en;
            extract_fail <= extract_activate & {4{trail_fail_action}};
        end
    end

    // One-second accumulation; an error in the tick cycle opens the next second
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ebc_acc <= '0;
            nds_seen <= 1'b0;
            fds_seen <= 1'b0;
        end
        else if (one_second_tick)
        begin
            ebc_acc <= COUNT_W'(near_block_error);
            nds_seen <= trail_fail_action || equipment_defect;
            fds_seen <= remote_defect_condition;
        end
        else
        begin
            if (near_block_error && ebc_acc != '1)
            begin
                ebc_acc <= ebc_acc + 1'b1;
            end
            nds_seen <= nds_seen || trail_fail_action || equipment_defect;
            fds_seen <= fds_seen || remote_defect_condition;
        end
    end

    // Reported totals refresh on each tick
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            near_errored_block_count <= '0;
            near_defect_second <= 1'b0;
            far_defect_second <= 1'b0;
            pm_valid <= 1'b0;
        end
        else
        begin
            pm_valid <= one_second_tick;
            if (one_second_tick)
            begin
                near_errored_block_count <= ebc_acc;
                near_defect_second <= nds_seen || trail_fail_action || equipment_defect;
                far_defect_second <= fds_seen || remote_defect_condition;
            end
        end
    end
endmodule

// ### rtl/pdhf_pkg.sv
// Behaviour
// - Frame is 2928 bits, 16-bit overhead first
// - Payload carries four 728-bit slots plus spare; the code gives all 2912 payload bits to the four slots
// - One active mapper; all others denied
// - Each extraction user individually deactivatable
// - Source writes overhead; payload passes unchanged
// - Remote defect bit follows request within 900us
// - Source sends alignment word 111110100000
// - Sink counts alignment mismatch as errored block
// - Sink takes remote defect bit, 1=defect
// - Sink detects remote defect condition
// - Remote defect report needs condition, monitor, enable
// - Server fail report needs fail, monitor, enable
// - Per second: block count, near, far flags
// - Mapper inserts tributary into selected slot
// - Elastic store written by tributary, read by path
// - Justification skips one read, stuffs J bit
// - Store deep enough for +-20 ppm
// - Mapper sends five control bits per frame
// - Slot parameter 1 to 4 picks slot
// - Mapper drives point only while activated
package pdhf_pkg;
    localparam int FRAME_BITS = 2928;
    localparam int POS_W = 12;
    localparam int OVH_BITS = 16;
    localparam int FAS_BITS = 12;
    localparam logic [11:0] FAS_PATTERN = 12'hfa0;
    localparam logic [11:0] RDI_POS = 12'h00c;
    localparam logic [11:0] NAT_FIRST_POS = 12'h00d;
    localparam int SET_BITS = 488;
    localparam int CTRL_BITS = 4;
    localparam int JUST_SET = 5;
    localparam int SLOTS = 4;
    localparam int STORE_AW = 6;
    localparam int STORE_DEPTH = 64;
    localparam logic [6:0] STORE_MID = 7'h20;
    localparam logic [6:0] STORE_FULL = 7'h3f;
    localparam int COUNT_W = 16;
    localparam logic [2:0] RDI_PERSIST = 3'h5;
    localparam logic TP_MONITORED = 1'b1;

    // Set number of a frame position
    function automatic int set_of(input logic [11:0] pos);
        set_of = int'(pos) / SET_BITS;
    endfunction

    // Justification control positions open sets two to six
    function automatic logic is_ctrl(input logic [11:0] pos);
        is_ctrl = (set_of(pos) >= 1) && ((int'(pos) % SET_BITS) < CTRL_BITS);
    endfunction

    // Justification opportunity bits follow the control bits of set six
    function automatic logic is_just(input logic [11:0] pos);
        int off;
        off = int'(pos) % SET_BITS;
        is_just = (set_of(pos) == JUST_SET) && (off >= CTRL_BITS) && (off < 2 * CTRL_BITS);
    endfunction
endpackage

// ### verif/pdhf_far_end.sv
`timescale 1ns/1ps
module pdhf_far_end
    import pdhf_pkg::*;
(
    input wire logic [3:0] bad_bit,
    output logic line_rx_clock,
    output logic line_rx_data,
    output logic line_rx_frame_start,
    output logic tributary_clock_in,
    output logic tributary_data_in
);
    int frame_no;
    int pos;
    logic [15:0] tcnt;

    // Back-to-back frames, so the link clock never pauses; frame one gets one bad FAS bit
    initial
    begin
        line_rx_clock = 1'b0;
        line_rx_data = 1'b0;
        line_rx_frame_start = 1'b0;
        frame_no = 0;
        #400.7;
        forever
        begin
            for (pos = 0; pos < FRAME_BITS; pos++)
            begin
                line_rx_frame_start = (pos == 0);
                if (pos < FAS_BITS)
                    line_rx_data = FAS_PATTERN[11 - pos] ^ (frame_no == 1 && pos == int'(bad_bit));
                else if (pos == 12)
                    line_rx_data = 1'b0;
                else
                    line_rx_data = pos[0] ^ pos[5];
                #80 line_rx_clock = 1'b1;
                #80 line_rx_clock = 1'b0;
            end
            frame_no++;
        end
    end

    // Tributary near nominal rate, scaled to the bench path clock
    initial
    begin
        tributary_clock_in = 1'b0;
        tributary_data_in = 1'b0;
        tcnt = 16'h0;
        #513.3;
        forever
        begin
            tributary_data_in = tcnt[0] ^ tcnt[4];
            #324 tributary_clock_in = 1'b1;
            #324 tributary_clock_in = 1'b0;
            tcnt++;
        end
    end
endmodule

// ### verif/pdhf_path_framer_properties.sv
`timescale 1ns/1ps
module pdhf_path_framer_properties
    import pdhf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mapper_activate,
    input wire logic other_source_deny,
    input wire logic payload_drive_en,
    input wire logic server_signal_fail_in,
    input wire logic trail_signal_fail_out,
    input wire logic remote_defect_request,
    input wire logic termination_point_setting,
    input wire logic server_fail_report_en,
    input wire logic remote_defect_report_en,
    input wire logic server_fail_correlated,
    input wire logic remote_defect_correlated,
    input wire logic near_block_error,
    input wire logic one_second_tick,
    input wire logic pm_valid,
    input wire logic [COUNT_W-1:0] near_errored_block_count,
    input wire logic [6:0] store_fill,
    input wire logic [3:0] extract_activate,
    input wire logic [3:0] extract_fail,
    input wire logic line_tx_frame_start
);
    // One domain, so clock and disable are stated once
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    deny_tracks_active_a: assert property (other_source_deny == mapper_activate)
        else $error("deny output differs from mapper activation");
    idle_no_drive_a: assert property (!mapper_activate && !$past(mapper_activate)
        && !$past(mapper_activate, 2) |-> !payload_drive_en)
        else $error("payload point driven while mapper inactive");
    fail_follows_ssf_a: assert property (trail_signal_fail_out == $past(server_signal_fail_in))
        else $error("trail fail does not follow server fail");
    request_follows_ssf_a: assert property (remote_defect_request == $past(server_signal_fail_in))
        else $error("defect request does not follow server fail");
    ssf_report_gate_a: assert property (server_fail_correlated == $past(server_signal_fail_in
        && termination_point_setting == TP_MONITORED && server_fail_report_en))
        else $error("server fail correlation wrong");
    rdi_report_gate_a: assert property (!$past(remote_defect_report_en)
        || $past(termination_point_setting) != TP_MONITORED |-> !remote_defect_correlated)
        else $error("remote defect reported while not enabled");
    error_one_cycle_a: assert property (near_block_error |=> !near_block_error)
        else $error("block error pulse longer than one cycle");
    pm_after_tick_a: assert property (pm_valid == $past(one_second_tick))
        else $error("pm valid not one cycle after tick");
    count_held_a: assert property (!$past(one_second_tick) |-> $stable(near_errored_block_count))
        else $error("block count changed between ticks");
    store_in_range_a: assert property (store_fill <= STORE_FULL)
        else $error("store fill beyond capacity");
    extract_gated_a: assert property ((extract_fail & ~$past(extract_activate)) == 4'h0)
        else $error("fault raised on deactivated extraction");
    tx_start_width_a: assert property ($rose(line_tx_frame_start) |=> line_tx_frame_start [*5])
        else $error("tx frame start shorter than one bit");
endmodule

bind pdhf_path_framer pdhf_path_framer_properties u_props (.clk_sys, .reset, .mapper_activate,
    .other_source_deny, .payload_drive_en, .server_signal_fail_in, .trail_signal_fail_out,
    .remote_defect_request, .termination_point_setting, .server_fail_report_en,
    .remote_defect_report_en, .server_fail_correlated, .remote_defect_correlated,
    .near_block_error, .one_second_tick, .pm_valid, .near_errored_block_count, .store_fill,
    .extract_activate, .extract_fail, .line_tx_frame_start);

// ### verif/tb_pdh_139m_path_framer.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin errors++; \
    $display("BAD %s exp %0h seen %0h", n, e, s); end end
module tb_pdh_139m_path_framer
    import pdhf_pkg::*;
;
    logic clk_sys, reset, path_timing_clock, path_timing_frame_start, payload_data_in;
    logic line_tx_data, line_tx_frame_start, tributary_data_in, tributary_clock_in;
    logic mapper_activate, justify_flag, line_rx_data, line_rx_clock, line_rx_frame_start;
    logic server_signal_fail_in, termination_point_setting, remote_defect_report_en;
    logic server_fail_report_en, one_second_tick, equipment_defect, remote_defect_request;
    logic near_block_error, near_defect_second, far_defect_second, pm_valid, rdi_exp, jus;
    logic [2:0] national_use_bits, tributary_slot;
    logic [3:0] extract_activate, bad_bit;
    logic [COUNT_W-1:0] near_errored_block_count;
    logic [31:0] seed;
    int errors, compares, tidx, tfr, nbe, pcnt, ppos;

    pdhf_path_framer uut (.clk_sys, .reset, .path_timing_clock, .path_timing_frame_start,
        .payload_data_in, .national_use_bits, .line_tx_data, .line_tx_frame_start,
        .payload_data_out(), .payload_drive_en(), .other_source_deny(), .tributary_data_in,
        .tributary_clock_in, .mapper_activate, .tributary_slot, .store_fill(), .justify_flag,
        .line_rx_data, .line_rx_clock, .line_rx_frame_start, .server_signal_fail_in,
        .termination_point_setting, .remote_defect_report_en, .server_fail_report_en,
        .one_second_tick, .equipment_defect, .extract_activate, .trail_signal_fail_out(),
        .remote_defect_request, .remote_defect_condition(), .remote_defect_correlated(),
        .server_fail_correlated(), .near_block_error, .near_errored_block_count,
        .near_defect_second, .far_defect_second, .pm_valid, .rx_payload_data(),
        .payload_frame_start(), .extract_fail());

    pdhf_far_end far_end (.bad_bit, .line_rx_clock, .line_rx_data, .line_rx_frame_start,
        .tributary_clock_in, .tributary_data_in);

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction

    task automatic wait_us(input int n);
        repeat (n * 50) @(negedge clk_sys);
    endtask

    task automatic wrap_up;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One tick; outputs land one cycle later, totals held while pm_valid pulses
    task automatic tick_check(input logic [COUNT_W-1:0] cnt, input logic nds, input logic fds);
        @(negedge clk_sys);
        one_second_tick = 1'b1;
        @(negedge clk_sys);
        one_second_tick = 1'b0;
        `CHK("pm_valid", 1'b1, pm_valid)
        `CHK("block_count", cnt, near_errored_block_count)
        `CHK("near_ds", nds, near_defect_second)
        `CHK("far_ds", fds, far_defect_second)
    endtask

    initial
    begin
        clk_sys = 1'b1;
        forever #10 clk_sys = ~clk_sys;
    end

    // Path bit clock of eight cycles a bit, plus random management levels
    always @(negedge clk_sys)
    begin
        seed <= xs(seed);
        termination_point_setting <= seed[0];
        remote_defect_report_en <= seed[1];
        server_fail_report_en <= seed[2];
        extract_activate <= seed[6:3];
        payload_data_in <= seed[7];
        if (!reset)
        begin
            pcnt <= (pcnt == 7) ? 0 : pcnt + 1;
            path_timing_clock <= (pcnt < 4);
            if (pcnt == 0)
            begin
                path_timing_frame_start <= (ppos == 0);
                ppos <= (ppos == FRAME_BITS - 1) ? 0 : ppos + 1;
                if (ppos == 0)
                    national_use_bits <= seed[10:8];
            end
        end
    end

    // Sampled one bit later than emission, when the line bit is settled
    always @(posedge path_timing_clock)
    begin
        if (line_tx_frame_start === 1'b1)
        begin
            if (tfr > 0)
                `CHK("frame_len", FRAME_BITS - 1, tidx)
            tidx = 0;
            tfr++;
            rdi_exp = server_signal_fail_in;
            jus = justify_flag;
        end
        else
            tidx++;
        if (tfr == 0)
            ;
        else if (tidx < 12)
            `CHK("fas", FAS_PATTERN[11 - tidx], line_tx_data)
        else if (tidx == 12)
            `CHK("rdi", rdi_exp, line_tx_data)
        else if (tidx < 16)
            `CHK("national", national_use_bits[15 - tidx], line_tx_data)
        else if (mapper_activate && tidx >= 488 && tidx % 488 == int'(tributary_slot) - 1)
            `CHK("cbit", jus, line_tx_data)
        else if (mapper_activate && jus && tidx == 2443 + int'(tributary_slot))
            `CHK("jbit", 1'b0, line_tx_data)
    end

    always @(negedge clk_sys)
    begin
        if (near_block_error === 1'b1)
            nbe++;
    end

    initial
    begin
        #1_800_000;
        errors++;
        wrap_up;
    end

    // Main sequence: server fail in second one, bad rx frame one, equipment defect later
    initial
    begin
        errors = 0;
        compares = 0;
        tfr = 0;
        nbe = 0;
        pcnt = 0;
        ppos = 0;
        seed = 32'h43b1;
        reset = 1'b1;
        path_timing_clock = 1'b0;
        path_timing_frame_start = 1'b0;
        payload_data_in = 1'b0;
        national_use_bits = 3'h0;
        mapper_activate = 1'b0;
        tributary_slot = 3'h1;
        server_signal_fail_in = 1'b0;
        termination_point_setting = 1'b0;
        remote_defect_report_en = 1'b0;
        server_fail_report_en = 1'b0;
        one_second_tick = 1'b0;
        equipment_defect = 1'b0;
        extract_activate = 4'h0;
        bad_bit = 4'(seed % 12);
        repeat (16) @(negedge clk_sys);
        reset = 1'b0;
        tributary_slot = {1'b0, seed[9:8]} + 3'h1;
        mapper_activate = 1'b1;
        tick_check(16'h0, 1'b0, 1'b0);
        wait_us(250);
        server_signal_fail_in = 1'b1;
        wait_us(450);
        server_signal_fail_in = 1'b0;
        wait_us(300);
        tick_check(16'h1, 1'b1, 1'b0);
        mapper_activate = 1'b0;
        wait_us(200);
        equipment_defect = 1'b1;
        wait_us(10);
        equipment_defect = 1'b0;
        wait_us(210);
        tick_check(16'h0, 1'b1, 1'b0);
        `CHK("block_errors", 1, nbe)
        `CHK("tx_frames", 1, tfr >= 3)
        wrap_up;
    end
endmodule
